/* File: hdl/tom_monitor.sv */
// Tape output word monitor: step reshaping, word capture, octal display
`timescale 1ns/1ns
`default_nettype none
`include "tom_regs.svh"

module tom_monitor #(
  parameter int unsigned STEP_DELAY_CYC =
    (`TOM_STEP_DELAY_US * `TOM_CLK_KHZ + 999) / 1000,
  parameter int unsigned STEP_WIDTH_CYC =
    (`TOM_STEP_WIDTH_US * `TOM_CLK_KHZ + 999) / 1000,
  parameter int unsigned EOR_CYC = `TOM_EOR_WIDTH_MS * `TOM_CLK_KHZ,
  parameter int unsigned EOF_CYC = `TOM_EOF_WIDTH_MS * `TOM_CLK_KHZ
) (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic          step_in,
  input  wire logic          data_line_0,
  input  wire logic          data_line_1,
  input  wire logic          data_line_2,
  input  wire logic          data_line_3,
  input  wire logic          frame_end_line,
  input  wire logic          gap_in,
  input  wire logic          eof_in,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [15:0]        reg_rdata,
  output logic               step_out,
  output logic               record_end_marker,
  output logic               record_end_led,
  output logic               eof_out,
  output logic               eof_led,
  output tom_pkg::tom_octal_s display
);

  localparam int unsigned STEP_MAX =
    (STEP_DELAY_CYC > STEP_WIDTH_CYC) ? STEP_DELAY_CYC : STEP_WIDTH_CYC;
  localparam int unsigned STEP_TW = $clog2(STEP_MAX + 1);
  localparam int unsigned EOR_TW  = $clog2(EOR_CYC + 1);
  localparam int unsigned EOF_TW  = $clog2(EOF_CYC + 1);
  localparam int unsigned NSYNC   = 8;
  localparam int unsigned NEDGE   = 4;

  if (STEP_DELAY_CYC < 1 || STEP_WIDTH_CYC < 1 || EOR_CYC < 1 ||
      EOF_CYC < 1) begin
    $error("tom_monitor: pulse counts must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // One-hot decimal decode; codes above nine decode to nothing
  function automatic logic [9:0] dec_digit(input logic [3:0] d);
    logic [9:0] r;
    r = '0;
    if (d <= 4'h9) begin
      r[d] = 1'b1;
    end
    return r;
  endfunction

  // Both digits of the count must hit the selected decoder lines
  function automatic logic digits_match(input tom_pkg::tom_bcd_s a,
                                        input tom_pkg::tom_bcd_s b);
    logic u;
    logic t;
    u = |(dec_digit(a.units) & dec_digit(b.units));
    t = |(dec_digit(a.tens) & dec_digit(b.tens));
    return u & t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  logic [NEDGE-1:0] prev_q;
  logic [NEDGE-1:0] rise;

  assign raw_in = {data_line_3, data_line_2, data_line_1, data_line_0,
                   eof_in, gap_in, frame_end_line, step_in};

  // Strobes come from another box; the first stage feeds only the second
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= raw_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  for (genvar i = 0; i < NEDGE; i++) begin : g_edge
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        prev_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= sync_q[i];
      end
    end
    assign rise[i] = sync_q[i] & ~prev_q[i];
  end

  logic       step_rise;
  logic       frame_rise;
  logic       gap_rise;
  logic       eof_rise;
  logic [3:0] nibble;

  assign step_rise  = rise[0];
  assign frame_rise = rise[1];
  assign gap_rise   = rise[2];
  assign eof_rise   = rise[3];
  assign nibble     = sync_q[7:4];

  ////////////////////////////////////////////////////////////////////////
  // Pulse timers

  logic step_busy;
  logic step_start;
  logic step_take;
  logic eor_busy;
  logic eof_busy;

  // A strobe arriving inside the previous one is dropped
  assign step_take = step_rise & ~step_busy;

  tom_pulse_timer #(
    .WIDTH  (STEP_TW),
    .DELAY  (STEP_DELAY_CYC),
    .LENGTH (STEP_WIDTH_CYC)
  ) u_step_timer (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .trigger     (step_rise),
    .busy        (step_busy),
    .pulse       (step_out),
    .pulse_start (step_start),
    .pulse_end   ()
  );

  // Gap start marks the record end
  tom_pulse_timer #(
    .WIDTH  (EOR_TW),
    .DELAY  (0),
    .LENGTH (EOR_CYC)
  ) u_eor_timer (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .trigger     (gap_rise),
    .busy        (eor_busy),
    .pulse       (),
    .pulse_start (),
    .pulse_end   ()
  );

  tom_pulse_timer #(
    .WIDTH  (EOF_TW),
    .DELAY  (0),
    .LENGTH (EOF_CYC)
  ) u_eof_timer (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .trigger     (eof_rise),
    .busy        (eof_busy),
    .pulse       (),
    .pulse_start (),
    .pulse_end   ()
  );

  // Indicator and recorder copies, each from its own flop
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      record_end_marker <= 1'b0;
      record_end_led    <= 1'b0;
      eof_out           <= 1'b0;
      eof_led           <= 1'b0;
    end else begin
      record_end_marker <= eor_busy;
      record_end_led    <= eor_busy;
      eof_out           <= eof_busy;
      eof_led           <= eof_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte select and holding latches

  logic       byte_sel_q;
  logic       second_ok_q;
  logic       word_done_q;
  logic [3:0] first_q;
  logic [3:0] second_q;

  // Low between steps means the next captured nibble is the first of the word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_sel_q <= 1'b0;
    end else if (frame_rise) begin
      byte_sel_q <= 1'b0;
    end else if (step_take) begin
      byte_sel_q <= ~byte_sel_q;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_q     <= 4'h0;
      second_q    <= 4'h0;
      second_ok_q <= 1'b0;
    end else if (step_start && byte_sel_q) begin
      first_q     <= nibble;
      second_ok_q <= 1'b0;
    end else if (step_start) begin
      second_q    <= nibble;
      second_ok_q <= 1'b1;
    end
  end

  // Set as the second nibble lands, one cycle after its capture strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      word_done_q <= 1'b0;
    end else begin
      word_done_q <= step_start & ~byte_sel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample counter, decimal

  tom_pkg::tom_bcd_s sample_q;
  tom_pkg::tom_bcd_s select_q;
  logic              hit;

  assign hit = digits_match(sample_q, select_q);

  // Tens digit runs on to nine although a frame only reaches 22
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_q <= '0;
    end else if (frame_rise) begin
      sample_q <= '0;
    end else if (word_done_q) begin
      if (sample_q.units == 4'h9) begin
        sample_q.units <= 4'h0;
        sample_q.tens  <= (sample_q.tens == 4'h9) ? 4'h0
                          : sample_q.tens + 4'h1;
      end else begin
        sample_q.units <= sample_q.units + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Octal display

  logic [15:0] frames_q;
  logic [15:0] loads_q;

  // Count still shows the word just completed when this fires
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      display <= `TOM_DISPLAY_RST;
    end else if (word_done_q && second_ok_q && hit) begin
      display.hi  <= {1'b0, first_q[3:2]};
      display.mid <= {first_q[1:0], second_q[3]};
      display.lo  <= second_q[2:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      loads_q <= 16'h0000;
    end else if (word_done_q && second_ok_q && hit) begin
      loads_q <= loads_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      frames_q <= 16'h0000;
    end else if (frame_rise) begin
      frames_q <= frames_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  // Selector stands in for the thumbwheels; any code is held as written
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      select_q <= `TOM_SELECT_RST;
    end else if (reg_wr && reg_addr == `TOM_REG_SELECT) begin
      select_q <= reg_wdata[7:0];
    end
  end

  logic [15:0] status;

  always_comb begin
    status                   = 16'h0000;
    status[`TOM_ST_BYTE_SEL]  = byte_sel_q;
    status[`TOM_ST_SECOND_OK] = second_ok_q;
    status[`TOM_ST_STEP_BUSY] = step_busy;
    status[`TOM_ST_EOR]       = eor_busy;
    status[`TOM_ST_EOF]       = eof_busy;
  end

  // Read data live for one cycle only; unmapped reads give zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `TOM_REG_SELECT:  reg_rdata <= {8'h00, select_q};
        `TOM_REG_DISPLAY: reg_rdata <= {7'h00, display};
        `TOM_REG_SAMPLE:  reg_rdata <= {8'h00, sample_q};
        `TOM_REG_STATUS:  reg_rdata <= status;
        `TOM_REG_FRAMES:  reg_rdata <= frames_q;
        `TOM_REG_LOADS:   reg_rdata <= loads_q;
        default:          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

`default_nettype wire

/* File: shared/tom_regs.svh */
// Constants for the tape output word monitor: times, offsets, fields, resets
`ifndef TOM_REGS_SVH
`define TOM_REGS_SVH

// Clock rate in kHz (25 MHz, 40 ns period)
`define TOM_CLK_KHZ        25000

// Pulse times in their own units
`define TOM_STEP_DELAY_US  300
`define TOM_STEP_WIDTH_US  300
`define TOM_EOR_WIDTH_MS   40
`define TOM_EOF_WIDTH_MS   900

// Register offsets (word index on the plain register port)
`define TOM_REG_SELECT     4'h0
`define TOM_REG_DISPLAY    4'h1
`define TOM_REG_SAMPLE     4'h2
`define TOM_REG_STATUS     4'h3
`define TOM_REG_FRAMES     4'h4
`define TOM_REG_LOADS      4'h5

// Field positions
`define TOM_SEL_UNITS_LSB  0
`define TOM_SEL_TENS_LSB   4
`define TOM_ST_BYTE_SEL    0
`define TOM_ST_SECOND_OK   1
`define TOM_ST_STEP_BUSY   2
`define TOM_ST_EOR         3
`define TOM_ST_EOF         4

// Reset values
`define TOM_SELECT_RST     8'h00
`define TOM_DISPLAY_RST    9'h000

// Input synchroniser depth
`define TOM_SYNC_STAGES    2

`endif

/* File: shared/tom_pkg.sv */
// Types shared by the tape output word monitor modules
`default_nettype none

package tom_pkg;

  // Pulse timer sequence
  typedef enum logic [1:0] {
    TM_IDLE,
    TM_DELAY,
    TM_PULSE
  } tom_timer_state_e;

  // Two decimal digits of a sample number or selector
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] units;
  } tom_bcd_s;

  // Three octal indicator digits, most significant first
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] mid;
    logic [2:0] lo;
  } tom_octal_s;

endpackage

`default_nettype wire

/* File: hdl/tom_pulse_timer.sv */
// Delayed, fixed-length pulse generator replacing a monostable pair
`timescale 1ns/1ns
`default_nettype none

module tom_pulse_timer #(
  parameter int unsigned WIDTH  = 16,
  parameter int unsigned DELAY  = 1,
  parameter int unsigned LENGTH = 1
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic trigger,
  output logic      busy,
  output logic      pulse,
  output logic      pulse_start,
  output logic      pulse_end
);

  localparam logic [WIDTH-1:0] DLY_M1 =
    (DELAY == 0) ? '0 : WIDTH'(DELAY - 1);
  localparam logic [WIDTH-1:0] LEN_M1 = WIDTH'(LENGTH - 1);

  if (LENGTH < 1 || LENGTH >= (2 ** WIDTH) || DELAY >= (2 ** WIDTH)) begin
    $error("tom_pulse_timer: counts do not fit WIDTH");
  end

  tom_pkg::tom_timer_state_e state_q;
  logic [WIDTH-1:0]          cnt_q;

  // Non-retriggerable, like the monostables it replaces
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= tom_pkg::TM_IDLE;
      cnt_q       <= '0;
      pulse       <= 1'b0;
      pulse_start <= 1'b0;
      pulse_end   <= 1'b0;
    end else begin
      pulse_start <= 1'b0;
      pulse_end   <= 1'b0;
      unique case (state_q)
        tom_pkg::TM_IDLE: begin
          if (trigger && DELAY == 0) begin
            state_q     <= tom_pkg::TM_PULSE;
            cnt_q       <= LEN_M1;
            pulse       <= 1'b1;
            pulse_start <= 1'b1;
          end else if (trigger) begin
            state_q <= tom_pkg::TM_DELAY;
            cnt_q   <= DLY_M1;
          end
        end
        tom_pkg::TM_DELAY: begin
          if (cnt_q == '0) begin
            state_q     <= tom_pkg::TM_PULSE;
            cnt_q       <= LEN_M1;
            pulse       <= 1'b1;
            pulse_start <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        tom_pkg::TM_PULSE: begin
          if (cnt_q == '0) begin
            state_q   <= tom_pkg::TM_IDLE;
            pulse     <= 1'b0;
            pulse_end <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  assign busy = (state_q != tom_pkg::TM_IDLE);

endmodule

`default_nettype wire

/* File: verification/tom_check_monitor.sv */
// Checker on the monitor's timed outputs and display loading
`timescale 1ns/1ns
`default_nettype none

module tom_check #(
  parameter int unsigned STEP_DELAY_CYC = 4,
  parameter int unsigned STEP_WIDTH_CYC = 4,
  parameter int unsigned EOR_CYC        = 20,
  parameter int unsigned EOF_CYC        = 40
) (
  input wire logic                core_clk,
  input wire logic                reset_n,
  input wire logic                step_in,
  input wire logic                gap_in,
  input wire logic                eof_in,
  input wire logic                step_out,
  input wire logic                record_end_marker,
  input wire logic                record_end_led,
  input wire logic                eof_out,
  input wire logic                eof_led,
  input wire tom_pkg::tom_octal_s display
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  int unsigned step_hi_q;
  int unsigned eor_hi_q;
  int unsigned eof_hi_q;
  int unsigned since_q;
  logic        step_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // High time of each pulse, judged when it ends
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_hi_q <= '0;
      eor_hi_q  <= '0;
      eof_hi_q  <= '0;
    end else begin
      step_hi_q <= step_out ? step_hi_q + 32'h1 : '0;
      eor_hi_q  <= record_end_marker ? eor_hi_q + 32'h1 : '0;
      eof_hi_q  <= eof_out ? eof_hi_q + 32'h1 : '0;
    end
  end

  // Cycles since the last step rise; saturates so idle time never wraps
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_prev_q <= 1'b0;
      since_q     <= 32'h3e8;
    end else begin
      step_prev_q <= step_in;
      if (step_in && !step_prev_q)
        since_q <= 32'h1;
      else if (since_q < 32'h3e8)
        since_q <= since_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_gap_rise;
    $rose(gap_in);
  endsequence
  sequence s_eof_rise;
    $rose(eof_in);
  endsequence

  a_step_width: assert property ($fell(step_out) |-> step_hi_q == STEP_WIDTH_CYC)
    else $error("step pulse width wrong");
  a_step_delay: assert property ($rose(step_out) |-> since_q == STEP_DELAY_CYC + 3)
    else $error("step delay wrong");
  a_eor_width: assert property ($fell(record_end_marker) |-> eor_hi_q == EOR_CYC)
    else $error("record end width wrong");
  a_eor_start: assert property (s_gap_rise |-> ##[1:8] $rose(record_end_marker))
    else $error("record end pulse missing");
  a_eor_led: assert property (record_end_led == record_end_marker)
    else $error("record end indicator differs");
  a_eof_width: assert property ($fell(eof_out) |-> eof_hi_q == EOF_CYC)
    else $error("end of file width wrong");
  a_eof_start: assert property (s_eof_rise |-> ##[1:8] $rose(eof_out))
    else $error("end of file pulse missing");
  a_eof_led: assert property (eof_led == eof_out)
    else $error("end of file indicator differs");
  a_disp_cause: assert property (!$stable(display) |-> $past(step_out, 2))
    else $error("display changed without a step");
endmodule

bind tom_monitor tom_check #(
  .STEP_DELAY_CYC (STEP_DELAY_CYC),
  .STEP_WIDTH_CYC (STEP_WIDTH_CYC),
  .EOR_CYC        (EOR_CYC),
  .EOF_CYC        (EOF_CYC)
) tom_check_inst (
  .core_clk          (core_clk),
  .reset_n           (reset_n),
  .step_in           (step_in),
  .gap_in            (gap_in),
  .eof_in            (eof_in),
  .step_out          (step_out),
  .record_end_marker (record_end_marker),
  .record_end_led    (record_end_led),
  .eof_out           (eof_out),
  .eof_led           (eof_led),
  .display           (display)
);

`default_nettype wire

/* File: verification/tom_tu_model.sv */
// Transcription unit stand-in; counts steps reaching the recorder
`timescale 1ns/1ns
`default_nettype none

module tom_tu_model (
  input  wire logic core_clk,
  input  wire logic step_out,
  output logic      step_in,
  output logic      data_line_0,
  output logic      data_line_1,
  output logic      data_line_2,
  output logic      data_line_3,
  output logic      frame_end_line,
  output logic      gap_in,
  output logic      eof_in,
  output int        steps_seen
);
  logic [3:0] nib_q = 4'h0;
  int         cnt   = 0;

  assign {data_line_3, data_line_2, data_line_1, data_line_0} = nib_q;
  assign steps_seen = cnt;

  always @(posedge step_out) cnt++;

  initial begin
    step_in        = 1'b0;
    frame_end_line = 1'b0;
    gap_in         = 1'b0;
    eof_in         = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lines held past the capture, then inverted so stale data never matches
  task automatic send_nib(input logic [3:0] n);
    @(posedge core_clk);
    nib_q   <= n;
    step_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    step_in <= 1'b0;
    repeat (10) @(posedge core_clk);
    nib_q   <= ~n;
  endtask

  task automatic send_word(input logic [7:0] w);
    send_nib(w[7:4]);
    send_nib(w[3:0]);
  endtask

  task automatic end_frame();
    @(posedge core_clk);
    frame_end_line <= 1'b1;
    repeat (2) @(posedge core_clk);
    frame_end_line <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic gap_pulse();
    @(posedge core_clk);
    gap_in <= 1'b1;
    repeat (30) @(posedge core_clk);
    gap_in <= 1'b0;
  endtask

  task automatic eof_pulse();
    @(posedge core_clk);
    eof_in <= 1'b1;
    repeat (3) @(posedge core_clk);
    eof_in <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the tape output word monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %0t got %h exp %h", $time, g, e); end end

module tb;
  localparam int RECORD_END_MARKER = 20;
  localparam int EOF = 40;
  localparam int SEL_TAB [5] = '{0, 21, 9, 10, 11};

  logic                core_clk  = 1'b0;
  logic                reset_n   = 1'b0;
  logic [3:0]          reg_addr  = 4'h0;
  logic [15:0]         reg_wdata = 16'h0000;
  logic                reg_wr    = 1'b0;
  logic                reg_rd    = 1'b0;
  logic [15:0]         reg_rdata;
  logic                step_in, frame_end_line, gap_in, eof_in;
  logic                data_line_0, data_line_1, data_line_2, data_line_3;
  logic                step_out, record_end_marker, record_end_led;
  logic                eof_out, eof_led;
  tom_pkg::tom_octal_s display;
  int                  steps;
  int                  err_count  = 0;
  int                  num_checks = 0;

  always #20 core_clk = ~core_clk;

  tom_monitor #(.STEP_DELAY_CYC(4), .STEP_WIDTH_CYC(4), .EOR_CYC(RECORD_END_MARKER),
    .EOF_CYC(EOF)) tom_monitor_inst (
    .core_clk          (core_clk),
    .reset_n           (reset_n),
    .step_in           (step_in),
    .data_line_0       (data_line_0),
    .data_line_1       (data_line_1),
    .data_line_2       (data_line_2),
    .data_line_3       (data_line_3),
    .frame_end_line    (frame_end_line),
    .gap_in            (gap_in),
    .eof_in            (eof_in),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .step_out          (step_out),
    .record_end_marker (record_end_marker),
    .record_end_led    (record_end_led),
    .eof_out           (eof_out),
    .eof_led           (eof_led),
    .display           (display)
  );
  tom_tu_model tom_tu_model_inst (
    .core_clk       (core_clk),
    .step_out       (step_out),
    .step_in        (step_in),
    .data_line_0    (data_line_0),
    .data_line_1    (data_line_1),
    .data_line_2    (data_line_2),
    .data_line_3    (data_line_3),
    .frame_end_line (frame_end_line),
    .gap_in         (gap_in),
    .eof_in         (eof_in),
    .steps_seen     (steps)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic tom_pkg::tom_octal_s exp_disp(input logic [7:0] w);
    exp_disp.hi  = {1'b0, w[7:6]};
    exp_disp.mid = w[5:3];
    exp_disp.lo  = w[2:0];
  endfunction

  function automatic logic [7:0] bcd(input int n);
    return {4'(n / 10), 4'(n % 10)};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // Waits for an output pulse, then counts its high cycles
  task automatic meas(input bit e, input int exp_n);
    int n;
    int t;
    n = 0;
    t = 0;
    while (!(e ? eof_out : record_end_marker) && t < 50) begin
      @(posedge core_clk);
      #1 t++;
    end
    while ((e ? eof_out : record_end_marker) && n < 100) begin
      @(posedge core_clk);
      #1 n++;
    end
    `CHK(n, exp_n)
  endtask

  task automatic run_frame(input int sel);
    logic [7:0] w [22];
    for (int i = 0; i < 22; i++) w[i] = 8'($urandom);
    w[9]  = 8'o200;
    w[10] = 8'o372;
    w[11] = 8'o005;
    wr(4'h0, {8'h00, bcd(sel)});
    rd(4'h0, {8'h00, bcd(sel)});
    for (int i = 0; i < 22; i++) tom_tu_model_inst.send_word(w[i]);
    repeat (2) @(posedge core_clk);
    #1 `CHK(display, exp_disp(w[sel]))
    rd(4'h1, {7'h00, exp_disp(w[sel])});
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'h0022);
    tom_tu_model_inst.end_frame();
    rd(4'h2, 16'h0000);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'hcf307912));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(4'hf, 16'h0000);
    for (int f = 0; f < 9; f++)
      run_frame((f < 5) ? SEL_TAB[f] : int'($urandom_range(21)));
    `CHK(steps, 9 * 44)
    rd(4'h4, 16'h0009);
    rd(4'h5, 16'h0009);
    // Units code above nine must never match any sample
    wr(4'h0, 16'h000a);
    for (int i = 0; i < 11; i++) tom_tu_model_inst.send_word(8'($urandom));
    rd(4'h5, 16'h0009);
    tom_tu_model_inst.end_frame();
    fork
      tom_tu_model_inst.gap_pulse();
      meas(1'b0, RECORD_END_MARKER);
    join
    fork
      tom_tu_model_inst.eof_pulse();
      meas(1'b1, EOF);
    join
    rd(4'h3, 16'h0002);
    print_verdict();
  end
endmodule

`default_nettype wire
